// file: rtl/cac_alu.v
// x register calculation unit, purely combinational
// assumes the caller registers the results and applies them only when ok
`timescale 1ns/1ps
`include "cac_regs.vh"

module cac_alu (
    input  wire [3:0]  op,
    input  wire [31:0] accu,
    input  wire [31:0] xreg,
    output reg  [31:0] accu_new,
    output reg  [31:0] x_new,
    output reg         ok
);

    // signed views for the arithmetic codes
    wire signed [31:0] a_s = accu;
    wire signed [31:0] x_s = xreg;
    wire signed [63:0] prod = a_s * x_s;   // full product, low half kept

    // operation select; accumulator is the first operand of every two-operand code
    always @* begin
        accu_new = accu;
        x_new    = xreg;
        ok       = 1'b1;
        case (op)
            `CAC_X_ADD: accu_new = accu + xreg;
            `CAC_X_SUB: accu_new = accu - xreg;
            `CAC_X_MUL: accu_new = prod[31:0];
            `CAC_X_DIV: begin
                // zero divisor refused rather than leaving junk behind
                if (xreg == 32'h00000000) ok = 1'b0;
                else accu_new = a_s / x_s;
            end
            `CAC_X_MOD: begin
                if (xreg == 32'h00000000) ok = 1'b0;
                else accu_new = a_s % x_s;
            end
            `CAC_X_AND: accu_new = accu & xreg;
            `CAC_X_OR:  accu_new = accu | xreg;
            `CAC_X_XOR: accu_new = accu ^ xreg;
            `CAC_X_NOT: x_new    = ~xreg;
            `CAC_X_LOAD: x_new   = accu;
            `CAC_X_SWAP: begin
                accu_new = xreg;
                x_new    = accu;
            end
            default: ok = 1'b0;     // unknown code, nothing changes
        endcase
    end

endmodule // cac_alu

// file: rtl/cac_core.v
// command execution core: coordinate array, accumulator and x register
// assumes one frame per valid cycle, synchronous inputs, and that the
// program sequencer drives cmd_direct low for stored-program commands
`timescale 1ns/1ps
`include "cac_regs.vh"

// Functional notes
// - get coordinate is 31, index 0 to 20
// - standalone get loads coordinate into accumulator
// - direct get replies value, accumulator untouched
// - successful direct get replies status 100
// - parameter 84 selects storage, resets volatile
// - coordinate zero never saved nor restored
// - index 0 motor 255 restores all others
// - nonzero index motor 255 restores one
// - capture 32 stores actual position
// - command 39 stores accumulator in coordinate
// - calculate 33 uses x, result in accumulator, in x for codes 8-9
// - codes 0-4 add sub mul div mod
// - codes 5-8 and or xor, invert x
// - code 9 loads x, 10 swaps
// - accumulator written to selected axis parameter
module cac_core #(
    parameter [7:0] MODULE_ADDR = 8'h01,  // target address answered
    parameter       N_COORD     = 21      // entries 0 .. 20
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        cmd_valid,
    input  wire        cmd_direct,
    input  wire [7:0]  cmd_addr,
    input  wire [7:0]  cmd_instr,
    input  wire [7:0]  cmd_type,
    input  wire [7:0]  cmd_motor,
    input  wire [31:0] cmd_value,
    input  wire [7:0]  cmd_csum,
    input  wire [31:0] act_pos,
    output reg         rpl_valid_q,
    output reg  [7:0]  rpl_instr_q,
    output reg  [7:0]  rpl_status_q,
    output reg  [31:0] rpl_value_q,
    output reg         ap_wr_q,
    output reg  [7:0]  ap_num_q,
    output reg  [31:0] ap_value_q,
    output reg  [31:0] accu_q,
    output reg  [31:0] xreg_q,
    output reg         coord_nv_q
);

    // volatile coordinate array and its nonvolatile shadow
    reg [31:0] ram_q [0:N_COORD-1];
    reg [31:0] nv_q  [0:N_COORD-1];   // models retention: no reset

    // next-state values
    reg [31:0] accu_d;
    reg [31:0] xreg_d;
    reg        coord_nv_d;
    reg [7:0]  status_d;
    reg [31:0] value_d;
    reg        ram_we;          // single-entry volatile write
    reg        nv_we;           // single-entry nonvolatile write
    reg        nv_save_all;     // copy volatile to nonvolatile
    reg        nv_load_all;     // copy nonvolatile to volatile
    reg        nv_load_one;     // restore one entry
    reg [31:0] wr_data;
    reg        ap_wr_d;

    integer i;

    // checksum: low byte of the sum of the eight preceding bytes
    function [7:0] frame_sum;
        input [7:0]  a;
        input [7:0]  ins;
        input [7:0]  t;
        input [7:0]  m;
        input [31:0] v;
        begin
            frame_sum = a + ins + t + m + v[31:24] + v[23:16]
                      + v[15:8] + v[7:0];
        end
    endfunction

    // index legal for the array
    function idx_ok;
        input [7:0] t;
        begin
            idx_ok = (t <= `CAC_IDX_MAX);
        end
    endfunction

    wire [4:0]  idx     = cmd_type[4:0];
    wire        for_us  = cmd_valid && (cmd_addr == MODULE_ADDR);
    wire        csum_ok = (frame_sum(cmd_addr, cmd_instr, cmd_type,
                           cmd_motor, cmd_value) == cmd_csum);
    wire        motor_axis = (cmd_motor == `CAC_MOTOR_AXIS);
    wire        motor_nv   = (cmd_motor == `CAC_MOTOR_NV);
    wire        nv_form    = motor_nv && (cmd_value == 32'h00000000);
    wire [31:0] ram_rd  = ram_q[idx];

    // calculation results
    wire [31:0] alu_accu;
    wire [31:0] alu_x;
    wire        alu_ok;

    cac_alu u_alu (
        .op       (cmd_type[3:0]),
        .accu     (accu_q),
        .xreg     (xreg_q),
        .accu_new (alu_accu),
        .x_new    (alu_x),
        .ok       (alu_ok)
    );

    // command decode and execution plan
    always @* begin
        accu_d      = accu_q;
        xreg_d      = xreg_q;
        coord_nv_d  = coord_nv_q;
        status_d    = `CAC_ST_OK;
        value_d     = 32'h00000000;
        ram_we      = 1'b0;
        nv_we       = 1'b0;
        nv_save_all = 1'b0;
        nv_load_all = 1'b0;
        nv_load_one = 1'b0;
        wr_data     = 32'h00000000;
        ap_wr_d     = 1'b0;
        if (!csum_ok) begin
            status_d = `CAC_ST_CSUM;
        end else begin
            case (cmd_instr)
                `CAC_OP_GET_COORD: begin
                    if (!idx_ok(cmd_type))
                        status_d = `CAC_ST_TYPE;
                    else if (nv_form) begin
                        // restore forms, entry zero stays put
                        if (idx == 5'h00)
                            nv_load_all = 1'b1;
                        else
                            nv_load_one = 1'b1;
                    end else if (motor_axis) begin
                        value_d = ram_rd;
                        if (!cmd_direct)
                            accu_d = ram_rd;
                        // direct mode keeps the accumulator
                        // status stays ok with the value
                    end else
                        status_d = `CAC_ST_VALUE;
                end
                `CAC_OP_SCO: begin
                    if (!idx_ok(cmd_type))
                        status_d = `CAC_ST_TYPE;
                    else if (nv_form) begin
                        if (idx == 5'h00) nv_save_all = 1'b1;
                        else nv_we = 1'b1;
                        wr_data = ram_rd;
                    end else if (motor_axis) begin
                        ram_we  = 1'b1;
                        wr_data = cmd_value;
                    end else
                        status_d = `CAC_ST_VALUE;
                end
                `CAC_OP_CAPTURE: begin
                    if (!idx_ok(cmd_type))
                        status_d = `CAC_ST_TYPE;
                    else if (!motor_axis)
                        status_d = `CAC_ST_VALUE;
                    else begin
                        ram_we  = 1'b1;
                        wr_data = act_pos;
                        value_d = act_pos;
                    end
                end
                `CAC_OP_ACCU_COORD: begin
                    if (!idx_ok(cmd_type))
                        status_d = `CAC_ST_TYPE;
                    else if (!motor_axis)
                        status_d = `CAC_ST_VALUE;
                    else begin
                        ram_we  = 1'b1;
                        wr_data = accu_q;
                    end
                end
                `CAC_OP_XCALC: begin
                    if (cmd_type > {4'h0, `CAC_X_SWAP})
                        status_d = `CAC_ST_TYPE;
                    else if (!alu_ok)
                        status_d = `CAC_ST_VALUE;        // divide by zero
                    else begin
                        accu_d = alu_accu;
                        xreg_d = alu_x;
                    end
                end
                `CAC_OP_ACCU_AP: begin
                    if (!motor_axis)
                        status_d = `CAC_ST_VALUE;
                    else
                        ap_wr_d = 1'b1;
                end
                `CAC_OP_SGP: begin
                    // only the storage selector lives here
                    if (cmd_type == `CAC_GP_COORD_NV && motor_axis)
                        coord_nv_d = cmd_value[0];
                    else
                        status_d = `CAC_ST_TYPE;
                end
                default: status_d = `CAC_ST_CMD;
            endcase
        end
    end

    // control state, replies and axis parameter strobe
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rpl_valid_q  <= 1'b0;
            rpl_instr_q  <= 8'h00;
            rpl_status_q <= 8'h00;
            rpl_value_q  <= 32'h00000000;
            ap_wr_q      <= 1'b0;
            ap_num_q     <= 8'h00;
            ap_value_q   <= 32'h00000000;
            accu_q       <= 32'h00000000;
            xreg_q       <= 32'h00000000;
            coord_nv_q   <= `CAC_GP_NV_RESET;
        end else begin
            // frames for other addresses are not answered
            rpl_valid_q <= for_us;
            ap_wr_q     <= 1'b0;
            if (for_us) begin
                rpl_instr_q  <= cmd_instr;
                rpl_status_q <= status_d;
                rpl_value_q  <= value_d;
                accu_q       <= accu_d;
                xreg_q       <= xreg_d;
                coord_nv_q   <= coord_nv_d;
                ap_wr_q      <= ap_wr_d;
                if (ap_wr_d) begin
                    ap_num_q   <= cmd_type;
                    ap_value_q <= accu_q;
                end
            end
        end
    end

    // volatile coordinate array
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < N_COORD; i = i + 1)
                ram_q[i] <= 32'h00000000;
        end else if (for_us) begin
            if (ram_we)
                ram_q[idx] <= wr_data;
            // bulk restore skips entry zero
            for (i = 1; i < N_COORD; i = i + 1)
                if (nv_load_all || (nv_load_one && idx == i))
                    ram_q[i] <= nv_q[i];
        end
    end

    // nonvolatile shadow; kept without reset so it survives it
    // trade-off: restore on power-up is left to the loader, since the
    // setting itself comes up volatile-only
    always @(posedge ref_clk) begin
        if (for_us) begin
            for (i = 1; i < N_COORD; i = i + 1) begin
                if (nv_save_all)
                    nv_q[i] <= ram_q[i];
                else if (nv_we && idx == i)
                    nv_q[i] <= wr_data;
                else if (ram_we && coord_nv_q && idx == i)
                    nv_q[i] <= wr_data;
            end
        end
    end

endmodule // cac_core

// file: rtl/cac_regs.vh
// constants for the coordinate and accumulator command block
// assumes inclusion by bare name from every design file that needs it
`ifndef CAC_REGS_VH
`define CAC_REGS_VH

// instruction numbers
`define CAC_OP_SGP        8'h09
`define CAC_OP_ACCU_AP    8'h22
`define CAC_OP_SCO        8'h1E
`define CAC_OP_GET_COORD  8'h1F
`define CAC_OP_CAPTURE    8'h20
`define CAC_OP_XCALC      8'h21
`define CAC_OP_ACCU_COORD 8'h27

// global parameter selecting coordinate storage
`define CAC_GP_COORD_NV   8'h54
// reset value of that setting: volatile only
`define CAC_GP_NV_RESET   1'b0

// coordinate index range and special motor byte
`define CAC_IDX_MAX       8'h14
`define CAC_MOTOR_AXIS    8'h00
`define CAC_MOTOR_NV      8'hFF

// x register operation codes
`define CAC_X_ADD         4'h0
`define CAC_X_SUB         4'h1
`define CAC_X_MUL         4'h2
`define CAC_X_DIV         4'h3
`define CAC_X_MOD         4'h4
`define CAC_X_AND         4'h5
`define CAC_X_OR          4'h6
`define CAC_X_XOR         4'h7
`define CAC_X_NOT         4'h8
`define CAC_X_LOAD        4'h9
`define CAC_X_SWAP        4'hA

// reply status codes
`define CAC_ST_OK         8'h64
`define CAC_ST_CSUM       8'h01
`define CAC_ST_CMD        8'h02
`define CAC_ST_TYPE       8'h03
`define CAC_ST_VALUE      8'h04

`endif

// file: tb/cac_core_chk.sv
// checker for the command core, watching only its ports
// assumes one clock domain with the asynchronous low reset
`timescale 1ns/1ps
`include "cac_regs.vh"
module cac_core_chk #(
    parameter [7:0] MODULE_ADDR = 8'h01
) (
    input logic        ref_clk,
    input logic        rst_n,
    input logic        cmd_valid,
    input logic        cmd_direct,
    input logic [7:0]  cmd_addr,
    input logic [7:0]  cmd_instr,
    input logic [7:0]  cmd_type,
    input logic [7:0]  cmd_motor,
    input logic [31:0] cmd_value,
    input logic [7:0]  cmd_csum,
    input logic        rpl_valid_q,
    input logic [7:0]  rpl_status_q,
    input logic        ap_wr_q,
    input logic [7:0]  ap_num_q,
    input logic [31:0] ap_value_q,
    input logic [31:0] accu_q,
    input logic [31:0] xreg_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // addressed frame, then the same with a good checksum
    wire tk = cmd_valid && cmd_addr == MODULE_ADDR;
    wire [7:0] sum = cmd_addr + cmd_instr + cmd_type + cmd_motor
        + cmd_value[31:24] + cmd_value[23:16] + cmd_value[15:8]
        + cmd_value[7:0];
    wire gd = tk && sum == cmd_csum;
    wire get = gd && cmd_instr == `CAC_OP_GET_COORD;
    // get, capture and accumulator-to-coordinate commands whose index runs past the array
    wire far = gd && cmd_type > `CAC_IDX_MAX
        && cmd_instr inside {`CAC_OP_GET_COORD, `CAC_OP_CAPTURE,
                             `CAC_OP_ACCU_COORD};
    a_reply_next:
        assert property (tk |=> rpl_valid_q)
        else $error("no reply one cycle after a frame");
    a_foreign_silent:
        assert property (!tk |=> !rpl_valid_q)
        else $error("reply without an addressed frame");
    a_bad_sum:
        assert property (tk && !gd |=> rpl_status_q == `CAC_ST_CSUM
            && $stable(accu_q))
        else $error("bad checksum not refused");
    a_direct_keep:
        assert property (get && cmd_direct |=> $stable(accu_q))
        else $error("direct get changed the accumulator");
    a_get_ok:
        assert property (get && cmd_motor == 0
            && cmd_type <= `CAC_IDX_MAX |=> rpl_status_q == `CAC_ST_OK)
        else $error("valid get not reported ok");
    a_index_err:
        assert property (far |=> rpl_status_q != `CAC_ST_OK
            && $stable(accu_q) && $stable(xreg_q))
        else $error("index past the array accepted");
    a_param_strobe:
        assert property (ap_wr_q |-> rpl_valid_q
            && ap_value_q == $past(accu_q) && ap_num_q == $past(cmd_type))
        else $error("axis parameter write mismatch");
    a_swap_regs:
        assert property (gd && cmd_instr == `CAC_OP_XCALC
            && cmd_type == 8'h0A |=> accu_q == $past(xreg_q)
            && xreg_q == $past(accu_q))
        else $error("swap did not exchange registers");
    c_get_prog: cover property (get && !cmd_direct);
    c_divide: cover property (gd && cmd_instr == `CAC_OP_XCALC
        && cmd_type == 8'h03);
    c_param: cover property (ap_wr_q);
endmodule // cac_core_chk

bind cac_core cac_core_chk #(.MODULE_ADDR(MODULE_ADDR)) chk_u (
    .ref_clk, .rst_n, .cmd_valid, .cmd_direct, .cmd_addr, .cmd_instr,
    .cmd_type, .cmd_motor, .cmd_value, .cmd_csum, .rpl_valid_q,
    .rpl_status_q, .ap_wr_q, .ap_num_q, .ap_value_q, .accu_q, .xreg_q);

// file: tb/cac_host_model.sv
// host model: puts one command frame per call onto the core
// assumes the caller samples the reply right after send returns
`timescale 1ns/1ps
module cac_host_model (
    input  logic        ref_clk,
    output logic        cmd_valid,
    output logic        cmd_direct,
    output logic [7:0]  cmd_addr,
    output logic [7:0]  cmd_instr,
    output logic [7:0]  cmd_type,
    output logic [7:0]  cmd_motor,
    output logic [31:0] cmd_value,
    output logic [7:0]  cmd_csum
);
    // quiet lines before the first frame
    initial begin
        {cmd_valid, cmd_direct, cmd_addr, cmd_instr} = '0;
        {cmd_type, cmd_motor, cmd_value, cmd_csum} = '0;
    end
    // bad bumps the checksum so a refusal can be provoked
    task automatic send(input bit d, input logic [7:0] a, i, t, m,
                        input logic [31:0] v, input bit bad);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_direct <= d;
        cmd_addr <= a;
        cmd_instr <= i;
        cmd_type <= t;
        cmd_motor <= m;
        cmd_value <= v;
        cmd_csum <= a + i + t + m + v[31:24] + v[23:16] + v[15:8]
            + v[7:0] + {7'h00, bad};
        @(posedge ref_clk);
        // released type and value lines change so stale data cannot pass
        cmd_valid <= 1'b0;
        {cmd_type, cmd_value} <= ~{t, v};
        #1;
    endtask
endmodule // cac_host_model

// file: tb/test_coordinate_and_accu_commands.sv
// self-checking bench for the coordinate and accumulator core
// assumes the host model drives frames; a model here predicts replies
`timescale 1ns/1ps
`include "cac_regs.vh"
module test_coordinate_and_accu_commands;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] act_pos = 32'h0;
    wire         cmd_valid, cmd_direct, rpl_valid_q, ap_wr_q, coord_nv_q;
    wire [7:0]   cmd_addr, cmd_instr, cmd_type, cmd_motor, cmd_csum;
    wire [7:0]   rpl_instr_q, rpl_status_q, ap_num_q;
    wire [31:0]  cmd_value, rpl_value_q, ap_value_q, accu_q, xreg_q;
    // model: ram and shadow coordinates, accu, x, storage setting
    int cw[21], nw[21], ac, xr, nvs;
    int num_errors = 0, checked = 0, seed = 32'h8C82;
    always #12.5 ref_clk = ~ref_clk;
    cac_core dut_u (.ref_clk, .rst_n, .cmd_valid, .cmd_direct, .cmd_addr,
        .cmd_instr, .cmd_type, .cmd_motor, .cmd_value, .cmd_csum, .act_pos,
        .rpl_valid_q, .rpl_instr_q, .rpl_status_q, .rpl_value_q, .ap_wr_q,
        .ap_num_q, .ap_value_q, .accu_q, .xreg_q, .coord_nv_q);
    cac_host_model host (.ref_clk, .cmd_valid, .cmd_direct, .cmd_addr,
        .cmd_instr, .cmd_type, .cmd_motor, .cmd_value, .cmd_csum);
    task chk_v(input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_st(input logic [7:0] g, e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t status got %h exp %h", $time, g, e);
        end
    endtask
    task summarize;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // send one frame, predict its effect, compare every result
    task automatic run(input bit d, input logic [7:0] i, t, m,
                       input logic [31:0] v, input bit bad);
        int s, r;
        bit gv, aw;
        {s, r, gv, aw} = {32'd100, 32'd0, 2'b00};
        host.send(d, 8'h01, i, t, m, v, bad);
        if (bad) s = 1;
        else case (i)
        `CAC_OP_GET_COORD: if (t > 20) s = 3;
            else if (m == 0) begin
                {r, gv} = {cw[t], 1'b1};
                if (!d) ac = r;
            end else if (m != 255 || v != 0) s = 4;
            else if (t == 0) for (int k = 1; k < 21; k++) cw[k] = nw[k];
            else cw[t] = nw[t];
        `CAC_OP_SCO, `CAC_OP_CAPTURE, `CAC_OP_ACCU_COORD: if (t > 20) s = 3;
            else if (m != 0) s = 4;
            else begin
                r = i == `CAC_OP_SCO ? v
                  : i == `CAC_OP_CAPTURE ? act_pos : ac;
                cw[t] = r;
                if (nvs && t != 0) nw[t] = r;
                gv = i == `CAC_OP_CAPTURE;
            end
        `CAC_OP_XCALC: if (t > 10) s = 3;
            else if (t inside {3, 4} && xr == 0) s = 4;
            else case (t)
            0: ac += xr;
            1: ac -= xr;
            2: ac *= xr;
            3: ac /= xr;
            4: ac %= xr;
            5: ac &= xr;
            6: ac |= xr;
            7: ac ^= xr;
            8: xr = ~xr;
            9: xr = ac;
            default: {ac, xr} = {xr, ac};
            endcase
        `CAC_OP_ACCU_AP: if (m != 0) s = 4; else aw = 1;
        `CAC_OP_SGP: if (t != 84) s = 3; else nvs = v[0];
        default: s = 2;
        endcase
        chk_v(rpl_valid_q, 1);
        chk_st(rpl_instr_q, i);
        chk_st(rpl_status_q, s);
        if (gv) chk_v(rpl_value_q, r);
        else chk_v(rpl_value_q, 0);
        chk_v(accu_q, ac);
        chk_v(xreg_q, xr);
        chk_v(coord_nv_q, nvs);
        chk_v(ap_wr_q, aw);
        if (aw) chk_v(ap_value_q, ac);
        if (aw) chk_v(ap_num_q, t);
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        run(1, `CAC_OP_GET_COORD, 7, 0, 0, 0);
        // fill both copies, then overwrite ram only
        for (int p = 1; p >= 0; p--) begin
            run(1, `CAC_OP_SGP, 84, 0, p, 0);
            for (int k = 0; k < 21; k++)
                run(1, `CAC_OP_SCO, k, 0, $random(seed), 0);
        end
        run(1, `CAC_OP_GET_COORD, 5, 255, 0, 0);
        for (int k = 4; k < 7; k++)
            run(1, `CAC_OP_GET_COORD, k, 0, 0, 0);
        run(1, `CAC_OP_GET_COORD, 0, 255, 0, 0);
        for (int k = 0; k < 21; k++)
            run(0, `CAC_OP_GET_COORD, k, 0, 0, 0);
        @(posedge ref_clk) act_pos <= $random(seed);
        run(1, `CAC_OP_CAPTURE, 3, 0, 0, 0);
        run(1, `CAC_OP_ACCU_COORD, 20, 0, 0, 0);
        run(1, `CAC_OP_GET_COORD, 3, 0, 0, 0);
        run(1, `CAC_OP_GET_COORD, 20, 0, 0, 0);
        // random operands, every code and one beyond, zero divisors
        for (int n = 0; n < 36; n++) begin
            run(1, `CAC_OP_SCO, 1, 0, n % 13 == 3 ? 0 : $random(seed), 0);
            run(0, `CAC_OP_GET_COORD, 1, 0, 0, 0);
            run(1, `CAC_OP_XCALC, 9, 0, 0, 0);
            run(1, `CAC_OP_SCO, 1, 0, $random(seed), 0);
            run(0, `CAC_OP_GET_COORD, 1, 0, 0, 0);
            run(1, `CAC_OP_XCALC, n % 12, 0, 0, 0);
            run(1, `CAC_OP_ACCU_AP, n, 0, 0, 0);
        end
        run(1, `CAC_OP_GET_COORD, 21, 0, 0, 0);
        run(1, `CAC_OP_ACCU_COORD, 21, 0, 0, 0);
        run(1, `CAC_OP_GET_COORD, 2, 7, 0, 0);
        run(1, `CAC_OP_GET_COORD, 2, 255, 5, 0);
        run(1, `CAC_OP_SCO, 2, 0, 32'h1234, 1);
        run(1, `CAC_OP_GET_COORD, 2, 0, 0, 0);
        run(1, 8'h2A, 0, 0, 0, 0);
        run(1, `CAC_OP_ACCU_AP, 8, 1, 0, 0);
        host.send(1, 8'h02, `CAC_OP_GET_COORD, 1, 0, 0, 0);
        chk_v(rpl_valid_q, 0);
        summarize();
    end
    // cut a hung run short
    initial begin
        #1000000;
        num_errors++;
        summarize();
    end
endmodule // test_coordinate_and_accu_commands
